/* File: verilog/vref_ctrl_pkg.sv */
// Package for the converter front-end control block.
// Assumes one 20 MHz clock domain and a plain strobe register port.
package vref_ctrl_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned CODE_W = 24;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h3;
  localparam logic [ADDR_W-1:0] REG_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] REG_FULLSCALE = 4'h5;
  localparam logic [ADDR_W-1:0] REG_DATA = 4'h6;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h7;

  // ----------------------------------------
  // Config field positions
  // ----------------------------------------
  localparam int unsigned CFG_GAIN_LSB = 0;
  localparam int unsigned CFG_POLARITY = 3;
  localparam int unsigned CFG_VREF_SEL = 4;
  localparam int unsigned CFG_VREF_DET = 6;
  localparam int unsigned CFG_BURNOUT = 7;
  localparam int unsigned CFG_CHAN_LSB = 8;
  localparam int unsigned CFG_GPO_LSB = 16;

  // Status / event bit positions
  localparam int unsigned ST_MISSING = 0;
  localparam int unsigned ST_ERROR = 1;
  localparam int unsigned EV_READY = 0;
  localparam int unsigned EV_MISSING = 1;
  localparam int unsigned EV_CAL_ERR = 2;
  localparam int unsigned EV_CAL_DONE = 3;
  localparam int unsigned EV_W = 4;

  // Control register bits: start offset cal, start full-scale cal
  localparam int unsigned CTL_CAL_OFS = 0;
  localparam int unsigned CTL_CAL_FS = 1;

  // ----------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------
  localparam logic [CODE_W-1:0] OFFSET_RESET = 24'h800000;
  localparam logic [CODE_W-1:0] FULLSCALE_RESET = 24'h500000;
  localparam logic [CODE_W-1:0] CODE_ONES = 24'hFFFFFF;
  localparam logic [CODE_W-1:0] CODE_MID = 24'h800000;

  // Gain codes; 3'h1 and 3'h2 are reserved and fall back to gain 1
  localparam logic [2:0] GAIN_1 = 3'h0;
  localparam logic [2:0] GAIN_8 = 3'h3;
  localparam logic [2:0] GAIN_16 = 3'h4;
  localparam logic [2:0] GAIN_32 = 3'h5;
  localparam logic [2:0] GAIN_64 = 3'h6;
  localparam logic [2:0] GAIN_128 = 3'h7;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_OFS = 3'b010,
    CAL_FS = 3'b100
  } cal_state_e;

  typedef struct packed {
    logic [2:0] gain_code;
    logic unipolar;
    logic vref_source_select;
    logic vref_detect_enable;
    logic burnout_enable;
    logic [3:0] channel;
    logic [1:0] gpo_data;
  } config_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  // Analog comparator results and modulator sample, from the analog side
  typedef struct packed {
    logic vref_below_low;
    logic vref_above_high;
    logic sample_valid;
    logic signed [CODE_W-1:0] sample;
  } analog_in_s;

  typedef struct packed {
    logic [7:0] gain_factor;
    logic vref_pair_two_is_ref;
    logic [1:0] gpo_out;
    logic [1:0] gpo_oe;
    logic burnout_source_on;
    logic burnout_sink_on;
    logic [3:0] burnout_channel;
  } analog_ctl_s;

endpackage

/* File: verilog/vref_ctrl.sv */
// Front-end control logic: gain, reference choice, missing reference
// detect, output coding, burnout currents, calibration coefficients.
// Assumes comparator outputs and samples are synchronous to clk.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module vref_ctrl #(
  parameter int unsigned CAL_SAMPLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire vref_ctrl_pkg::bus_req_s bus_req,
  output logic [vref_ctrl_pkg::DATA_W-1:0] bus_rdata,
  // Analog side
  input wire vref_ctrl_pkg::analog_in_s analog_in,
  output vref_ctrl_pkg::analog_ctl_s analog_ctl,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    vref_ctrl_pkg::config_s cfg;
    logic missing_vref_flag;
    logic cal_error;
    logic [vref_ctrl_pkg::EV_W-1:0] irq_status;
    logic [vref_ctrl_pkg::EV_W-1:0] irq_mask;
    logic [vref_ctrl_pkg::CODE_W-1:0] offset_coef;
    logic [vref_ctrl_pkg::CODE_W-1:0] fullscale_coef;
    logic [vref_ctrl_pkg::CODE_W-1:0] data;
    vref_ctrl_pkg::cal_state_e cal_state;
    logic [7:0] cal_count;
    logic cal_bad;
    logic [vref_ctrl_pkg::DATA_W-1:0] rdata;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    case (code)
      vref_ctrl_pkg::GAIN_8: gain_of = 8'h08;
      vref_ctrl_pkg::GAIN_16: gain_of = 8'h10;
      vref_ctrl_pkg::GAIN_32: gain_of = 8'h20;
      vref_ctrl_pkg::GAIN_64: gain_of = 8'h40;
      vref_ctrl_pkg::GAIN_128: gain_of = 8'h80;
      default: gain_of = 8'h01;
    endcase
  endfunction

  // Sample is a signed fraction of full scale (input*gain/vref * 2^(N-1)).
  // Unipolar doubles it and clamps; bipolar adds midscale.
  function automatic logic [vref_ctrl_pkg::CODE_W-1:0] code_of(
    input logic signed [vref_ctrl_pkg::CODE_W-1:0] s,
    input logic uni
  );
    logic [vref_ctrl_pkg::CODE_W:0] dbl;
    dbl = {s, 1'b0};
    if (uni) begin
      if (s[vref_ctrl_pkg::CODE_W-1]) begin
        code_of = '0;
      end else begin
        code_of = dbl[vref_ctrl_pkg::CODE_W-1:0];
      end
    end else begin
      code_of = s ^ vref_ctrl_pkg::CODE_MID;
    end
  endfunction

  // One field layout serves both the write decode and the read back
  function automatic vref_ctrl_pkg::config_s cfg_from_word(
    input logic [vref_ctrl_pkg::DATA_W-1:0] w
  );
    cfg_from_word.gain_code = w[vref_ctrl_pkg::CFG_GAIN_LSB +: 3];
    cfg_from_word.unipolar = w[vref_ctrl_pkg::CFG_POLARITY];
    cfg_from_word.vref_source_select = w[vref_ctrl_pkg::CFG_VREF_SEL];
    cfg_from_word.vref_detect_enable = w[vref_ctrl_pkg::CFG_VREF_DET];
    cfg_from_word.burnout_enable = w[vref_ctrl_pkg::CFG_BURNOUT];
    cfg_from_word.channel = w[vref_ctrl_pkg::CFG_CHAN_LSB +: 4];
    cfg_from_word.gpo_data = w[vref_ctrl_pkg::CFG_GPO_LSB +: 2];
  endfunction

  // Unused bits read back as zero
  function automatic logic [vref_ctrl_pkg::DATA_W-1:0] word_from_cfg(
    input vref_ctrl_pkg::config_s c
  );
    word_from_cfg = '0;
    word_from_cfg[vref_ctrl_pkg::CFG_GAIN_LSB +: 3] = c.gain_code;
    word_from_cfg[vref_ctrl_pkg::CFG_POLARITY] = c.unipolar;
    word_from_cfg[vref_ctrl_pkg::CFG_VREF_SEL] = c.vref_source_select;
    word_from_cfg[vref_ctrl_pkg::CFG_VREF_DET] = c.vref_detect_enable;
    word_from_cfg[vref_ctrl_pkg::CFG_BURNOUT] = c.burnout_enable;
    word_from_cfg[vref_ctrl_pkg::CFG_CHAN_LSB +: 4] = c.channel;
    word_from_cfg[vref_ctrl_pkg::CFG_GPO_LSB +: 2] = c.gpo_data;
  endfunction

  // Arms a run; the error of the previous run is dropped here
  function automatic state_s start_cal(
    input state_s cur,
    input vref_ctrl_pkg::cal_state_e kind
  );
    start_cal = cur;
    start_cal.cal_state = kind;
    start_cal.cal_bad = 1'b0;
    start_cal.cal_error = 1'b0;
    start_cal.cal_count = '0;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [vref_ctrl_pkg::EV_W-1:0] events;
  logic [vref_ctrl_pkg::DATA_W-1:0] wd;
  logic detect_on;

  always_comb begin
    state_next = state_reg;
    events = '0;
    wd = bus_req.wdata;
    detect_on = state_reg.cfg.vref_detect_enable;

    // ----------------------------------------
    // Missing reference detect; held in the band
    // ----------------------------------------
    if (!detect_on) begin
      state_next.missing_vref_flag = 1'b0;
    end else if (analog_in.vref_below_low) begin
      state_next.missing_vref_flag = 1'b1;
    end else if (analog_in.vref_above_high) begin
      state_next.missing_vref_flag = 1'b0;
    end
    // Rise only, so a steady missing reference raises one event
    if (state_next.missing_vref_flag && !state_reg.missing_vref_flag) begin
      events[vref_ctrl_pkg::EV_MISSING] = 1'b1;
    end

    // ----------------------------------------
    // Conversions and calibration
    // ----------------------------------------
    case (state_reg.cal_state)
      vref_ctrl_pkg::CAL_IDLE: begin
        if (analog_in.sample_valid) begin
          if (state_reg.missing_vref_flag) begin
            state_next.data = vref_ctrl_pkg::CODE_ONES;
          end else begin
            state_next.data = code_of(analog_in.sample, state_reg.cfg.unipolar);
          end
          events[vref_ctrl_pkg::EV_READY] = 1'b1;
        end
      end
      vref_ctrl_pkg::CAL_OFS, vref_ctrl_pkg::CAL_FS: begin
        // Latched for the run: a reference that drops and returns still fails
        if (state_reg.missing_vref_flag) begin
          state_next.cal_bad = 1'b1;
        end
        if (analog_in.sample_valid) begin
          state_next.cal_count = state_reg.cal_count + 8'h01;
          if (state_reg.cal_count == 8'(CAL_SAMPLES - 1)) begin
            state_next.cal_state = vref_ctrl_pkg::CAL_IDLE;
            state_next.cal_count = '0;
            if (state_next.cal_bad) begin
              state_next.cal_error = 1'b1;
              events[vref_ctrl_pkg::EV_CAL_ERR] = 1'b1;
            end else if (state_reg.cal_state == vref_ctrl_pkg::CAL_OFS) begin
              state_next.offset_coef = analog_in.sample ^ vref_ctrl_pkg::CODE_MID;
            end else begin
              state_next.fullscale_coef = analog_in.sample;
            end
            events[vref_ctrl_pkg::EV_CAL_DONE] = 1'b1;
          end
        end
      end
      default: state_next.cal_state = vref_ctrl_pkg::CAL_IDLE;
    endcase

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (bus_req.wr) begin
      case (bus_req.addr)
        vref_ctrl_pkg::REG_CONFIG: state_next.cfg = cfg_from_word(wd);
        vref_ctrl_pkg::REG_IRQ_MASK: state_next.irq_mask = wd[vref_ctrl_pkg::EV_W-1:0];
        // Host writes only take effect while no calibration runs
        vref_ctrl_pkg::REG_OFFSET: begin
          if (state_reg.cal_state == vref_ctrl_pkg::CAL_IDLE) begin
            state_next.offset_coef = wd[vref_ctrl_pkg::CODE_W-1:0];
          end
        end
        vref_ctrl_pkg::REG_FULLSCALE: begin
          if (state_reg.cal_state == vref_ctrl_pkg::CAL_IDLE) begin
            state_next.fullscale_coef = wd[vref_ctrl_pkg::CODE_W-1:0];
          end
        end
        vref_ctrl_pkg::REG_CONTROL: begin
          if (state_reg.cal_state == vref_ctrl_pkg::CAL_IDLE) begin
            if (wd[vref_ctrl_pkg::CTL_CAL_OFS]) begin
              state_next = start_cal(state_next, vref_ctrl_pkg::CAL_OFS);
            end else if (wd[vref_ctrl_pkg::CTL_CAL_FS]) begin
              state_next = start_cal(state_next, vref_ctrl_pkg::CAL_FS);
            end
          end
        end
        default: ;
      endcase
    end

    // ----------------------------------------
    // Write-one-to-clear; a new event wins over the clear
    // ----------------------------------------
    if (bus_req.wr && bus_req.addr == vref_ctrl_pkg::REG_IRQ_STATUS) begin
      state_next.irq_status = state_reg.irq_status & ~wd[vref_ctrl_pkg::EV_W-1:0];
    end
    state_next.irq_status = state_next.irq_status | events;

    // ----------------------------------------
    // Read data, valid the cycle after the strobe only
    // ----------------------------------------
    state_next.rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        vref_ctrl_pkg::REG_CONFIG: state_next.rdata = word_from_cfg(state_reg.cfg);
        vref_ctrl_pkg::REG_STATUS: begin
          state_next.rdata[vref_ctrl_pkg::ST_MISSING] = state_reg.missing_vref_flag;
          state_next.rdata[vref_ctrl_pkg::ST_ERROR] = state_reg.cal_error;
        end
        vref_ctrl_pkg::REG_IRQ_STATUS:
          state_next.rdata[vref_ctrl_pkg::EV_W-1:0] = state_reg.irq_status;
        vref_ctrl_pkg::REG_IRQ_MASK:
          state_next.rdata[vref_ctrl_pkg::EV_W-1:0] = state_reg.irq_mask;
        vref_ctrl_pkg::REG_OFFSET:
          state_next.rdata[vref_ctrl_pkg::CODE_W-1:0] = state_reg.offset_coef;
        vref_ctrl_pkg::REG_FULLSCALE:
          state_next.rdata[vref_ctrl_pkg::CODE_W-1:0] = state_reg.fullscale_coef;
        vref_ctrl_pkg::REG_DATA:
          state_next.rdata[vref_ctrl_pkg::CODE_W-1:0] = state_reg.data;
        vref_ctrl_pkg::REG_CONTROL:
          state_next.rdata[2:0] = state_reg.cal_state;
        default: state_next.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.cal_state <= vref_ctrl_pkg::CAL_IDLE;
      state_reg.offset_coef <= vref_ctrl_pkg::OFFSET_RESET;
      state_reg.fullscale_coef <= vref_ctrl_pkg::FULLSCALE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus_rdata = state_reg.rdata;
  // Level output; stays high until every unmasked status bit is cleared
  assign irq = |(state_reg.irq_status & state_reg.irq_mask);

  // ----------------------------------------
  // Analog controls
  // ----------------------------------------
  // One bit drives both burnout currents, so they can never be split
  always_comb begin
    analog_ctl.gain_factor = gain_of(state_reg.cfg.gain_code);
    analog_ctl.vref_pair_two_is_ref = state_reg.cfg.vref_source_select;
    // Pair two pins drive outputs only while not used as reference
    analog_ctl.gpo_out = state_reg.cfg.gpo_data;
    analog_ctl.gpo_oe = {2{~state_reg.cfg.vref_source_select}};
    analog_ctl.burnout_source_on = state_reg.cfg.burnout_enable;
    analog_ctl.burnout_sink_on = state_reg.cfg.burnout_enable;
    analog_ctl.burnout_channel = state_reg.cfg.channel;
  end

endmodule

/* File: verif/vref_ctrl_monitor.sv */
// Checker for the front-end control block, watching its ports only.
// Assumes the single clk domain and active-low rst_n of the block.
`timescale 1ns/1ps

module vref_ctrl_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire vref_ctrl_pkg::bus_req_s bus_req,
  input wire logic [vref_ctrl_pkg::DATA_W-1:0] bus_rdata,
  // Analog side
  input wire vref_ctrl_pkg::analog_in_s analog_in,
  input wire vref_ctrl_pkg::analog_ctl_s analog_ctl,
  // Interrupt
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cfg_write;
    bus_req.wr && bus_req.addr == vref_ctrl_pkg::REG_CONFIG;
  endsequence

  a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
    else $error("read data not zero outside the answer cycle");
  a_rdata_upper_zero: assert property (bus_req.rd && bus_req.addr ==
    vref_ctrl_pkg::REG_OFFSET |=> bus_rdata[31:24] == 8'h00)
    else $error("offset read has upper bits set");
  a_gain_max_code: assert property (s_cfg_write ##0 bus_req.wdata[2:0] == 3'h7 |=>
    analog_ctl.gain_factor == 8'h80)
    else $error("gain code 7 did not give 128");
  a_gain_unity_code: assert property (s_cfg_write ##0 bus_req.wdata[2:0] < 3'h3 |=>
    analog_ctl.gain_factor == 8'h01)
    else $error("low gain codes did not give 1");
  a_ref_select_follows: assert property (s_cfg_write |=>
    analog_ctl.vref_pair_two_is_ref == $past(bus_req.wdata[4]))
    else $error("reference pair select not applied");
  a_pair_two_released: assert property (analog_ctl.vref_pair_two_is_ref |->
    analog_ctl.gpo_oe == 2'h0)
    else $error("pair two driven while used as reference");
  a_pair_two_driven: assert property (!analog_ctl.vref_pair_two_is_ref |->
    analog_ctl.gpo_oe == 2'h3)
    else $error("pair two not driven while free for outputs");
  a_burnout_paired: assert property (analog_ctl.burnout_source_on ==
    analog_ctl.burnout_sink_on)
    else $error("burnout currents not switched together");
  a_burnout_follows: assert property (s_cfg_write |=> analog_ctl.burnout_source_on ==
    $past(bus_req.wdata[7]) && analog_ctl.burnout_channel == $past(bus_req.wdata[11:8]))
    else $error("burnout enable or channel not applied");
endmodule

bind vref_ctrl vref_ctrl_monitor i_mon (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .analog_in(analog_in), .analog_ctl(analog_ctl), .irq(irq));

/* File: verif/analog_side_model.sv */
// Behavioural analog side: reference comparators and modulator samples.
// Assumes the bench moves vref_mv and fire just after a rising edge.
`timescale 1ns/1ps

module analog_side_model (
  // Stimulus from the bench
  input wire integer vref_mv,
  input wire logic fire,
  input wire logic signed [23:0] val,
  // Toward the block
  output vref_ctrl_pkg::analog_in_s analog_in
);
  // Outside the valid pulse the sample is scrambled, never left stale
  always_comb begin
    analog_in.vref_below_low = vref_mv < 300;
    analog_in.vref_above_high = vref_mv > 600;
    analog_in.sample_valid = fire;
    analog_in.sample = fire ? val : ~val;
  end
endmodule

/* File: verif/vref_ctrl_bench.sv */
// Self-checking bench for the front-end control block.
// Assumes the block answers reads one cycle after the read strobe.
`timescale 1ns/1ps

module vref_ctrl_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  vref_ctrl_pkg::bus_req_s bus_req = '0;
  logic [31:0] bus_rdata;
  vref_ctrl_pkg::analog_in_s analog_in;
  vref_ctrl_pkg::analog_ctl_s analog_ctl;
  logic irq;
  int vref_mv = 2500;
  logic fire = 1'b0;
  logic signed [23:0] val = '0;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] gf [8] = '{8'h01, 8'h01, 8'h01, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  logic [23:0] cod [8][3] = '{'{24'h0, 24'h000000, 24'h800000},
    '{24'h0, 24'h800000, 24'h000000}, '{24'h0, 24'h7FFFFF, 24'hFFFFFF},
    '{24'h8, 24'h000000, 24'h000000}, '{24'h8, 24'h400000, 24'h800000},
    '{24'h8, 24'h7FFFFF, 24'hFFFFFE}, '{24'h8, 24'hC00000, 24'h000000},
    '{24'h0, 24'h000001, 24'h800001}};

  always #25 clk = ~clk;

  vref_ctrl #(.CAL_SAMPLES(2)) i_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .analog_in(analog_in), .analog_ctl(analog_ctl), .irq(irq));
  analog_side_model i_far (.vref_mv(vref_mv), .fire(fire), .val(val), .analog_in(analog_in));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(bus_rdata, exp, what);
  endtask

  task automatic smp(input logic [23:0] v);
    @(posedge clk);
    fire <= 1'b1;
    val <= v;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic ref_to(input int mv);
    @(posedge clk);
    vref_mv <= mv;
    repeat (3) @(posedge clk);
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 160 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(vref_ctrl_pkg::REG_CONFIG, 32'h0, "config reset");
    rdc(vref_ctrl_pkg::REG_OFFSET, 32'h800000, "offset reset");
    rdc(vref_ctrl_pkg::REG_FULLSCALE, 32'h500000, "fullscale reset");
    rdc(4'h8, 32'h0, "unmapped read");
    for (int i = 0; i < 8; i++) begin
      wr(vref_ctrl_pkg::REG_CONFIG, 32'(i));
      chk({24'h0, analog_ctl.gain_factor}, {24'h0, gf[i]}, "gain factor");
    end
    wr(vref_ctrl_pkg::REG_CONFIG, 32'h0003_0010);
    chk({30'h0, analog_ctl.vref_pair_two_is_ref, 1'b0}, 32'h2, "pair two as ref");
    chk({30'h0, analog_ctl.gpo_oe}, 32'h0, "pair two released");
    wr(vref_ctrl_pkg::REG_CONFIG, 32'h0003_0000);
    chk({28'h0, analog_ctl.gpo_oe, analog_ctl.gpo_out}, 32'hF, "pair two as outputs");
    wr(vref_ctrl_pkg::REG_CONFIG, 32'h0000_0580);
    chk({26'h0, analog_ctl.burnout_source_on, analog_ctl.burnout_sink_on,
      analog_ctl.burnout_channel}, 32'h35, "burnout on");
    wr(vref_ctrl_pkg::REG_CONFIG, 32'h0000_0300);
    chk({26'h0, analog_ctl.burnout_source_on, analog_ctl.burnout_sink_on,
      analog_ctl.burnout_channel}, 32'h03, "burnout off");
    for (int i = 0; i < 8; i++) begin
      wr(vref_ctrl_pkg::REG_CONFIG, {8'h0, cod[i][0]});
      smp(cod[i][1]);
      rdc(vref_ctrl_pkg::REG_DATA, {8'h0, cod[i][2]}, "coded data");
    end
    wr(vref_ctrl_pkg::REG_CONFIG, 32'h0);
    wr(vref_ctrl_pkg::REG_IRQ_STATUS, 32'hF);
    wr(vref_ctrl_pkg::REG_IRQ_MASK, 32'h2);
    ref_to(0);
    rdc(vref_ctrl_pkg::REG_STATUS, 32'h0, "detect off");
    chk({31'h0, irq}, 32'h0, "irq quiet");
    wr(vref_ctrl_pkg::REG_CONFIG, 32'h40);
    rdc(vref_ctrl_pkg::REG_STATUS, 32'h1, "missing set");
    chk({31'h0, irq}, 32'h1, "irq raised");
    smp(24'h000123);
    rdc(vref_ctrl_pkg::REG_DATA, 32'hFFFFFF, "forced ones");
    ref_to(450);
    rdc(vref_ctrl_pkg::REG_STATUS, 32'h1, "flag held");
    wr(vref_ctrl_pkg::REG_IRQ_STATUS, 32'hF);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    ref_to(700);
    rdc(vref_ctrl_pkg::REG_STATUS, 32'h0, "missing cleared");
    wr(vref_ctrl_pkg::REG_CONTROL, 32'h1);
    smp(24'h000100);
    smp(24'h000200);
    rdc(vref_ctrl_pkg::REG_OFFSET, 32'h800200, "offset cal");
    rdc(vref_ctrl_pkg::REG_CONTROL, 32'h1, "cal idle");
    ref_to(0);
    wr(vref_ctrl_pkg::REG_CONTROL, 32'h2);
    wr(vref_ctrl_pkg::REG_OFFSET, 32'h111111);
    smp(24'h000300);
    smp(24'h000400);
    rdc(vref_ctrl_pkg::REG_FULLSCALE, 32'h500000, "fullscale kept");
    rdc(vref_ctrl_pkg::REG_STATUS, 32'h3, "cal error");
    rdc(vref_ctrl_pkg::REG_OFFSET, 32'h800200, "offset write in cal");
    rdc(vref_ctrl_pkg::REG_IRQ_STATUS, 32'hE, "cal events");
    rdc(vref_ctrl_pkg::REG_IRQ_MASK, 32'h2, "mask readback");
    chk({31'h0, irq}, 32'h1, "irq on missing");
    wr(vref_ctrl_pkg::REG_FULLSCALE, 32'h123456);
    rdc(vref_ctrl_pkg::REG_FULLSCALE, 32'h123456, "host write");
    conclude();
  end
endmodule
